// ---- cpu_regs_pkg.sv ----
package cpu_regs_pkg;

  // Program memory map
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_TABLE_END = 16'h0013;
  localparam logic [15:0] VEC_LOW_VOLT = 16'h0006;
  localparam logic [15:0] VEC_EXT0 = 16'h0008;
  localparam logic [15:0] VEC_EXT1 = 16'h000A;
  localparam logic [15:0] VEC_TIMER8 = 16'h000C;
  localparam logic [15:0] SHORT_TABLE_CALL_BASE = 16'h0040;
  localparam logic [15:0] SHORT_TABLE_CALL_END = 16'h007F;
  localparam logic [15:0] OPTION_ADDR = 16'h0080;
  localparam logic [15:0] PROTECT_ADDR = 16'h0081;
  localparam int unsigned FLASH_BYTES_DEFAULT = 4096;

  // Data memory map
  localparam logic [15:0] RAM_BASE = 16'hFE80;
  localparam logic [15:0] RAM_END = 16'hFEFF;
  localparam logic [15:0] SFR_BASE = 16'hFF00;
  localparam logic [15:0] SHORT_BASE = 16'hFE80;

  // Stack pointer: low bits writable, top bits fixed
  localparam int SP_BITS = 10;
  localparam logic [5:0] SP_HIGH = 6'h3E;
  localparam logic [9:0] SP_RESET = 10'h000;
  localparam logic [9:0] SP_ONE = 10'h001;

  // Status word layout
  localparam int IE_BIT = 7;
  localparam int Z_BIT = 6;
  localparam int AC_BIT = 4;
  localparam int ONE_BIT = 1;
  localparam int CY_BIT = 0;
  localparam logic [7:0] PSW_RESET = 8'h02;

  // Bus register offsets
  localparam logic [7:0] OFS_INSTR_POINTER = 8'h00;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
  localparam logic [7:0] OFS_STACK_PTR = 8'h08;
  localparam logic [7:0] OFS_CORE_STATE = 8'h0C;

  typedef enum logic [1:0] {
    F_RUN = 2'b00,
    F_LO = 2'b01,
    F_HI = 2'b10,
    F_DONE = 2'b11
  } fetch_t;

  typedef enum logic [2:0] {
    REGION_NONE = 3'b000,
    REGION_VECTOR = 3'b001,
    REGION_SHORT_TABLE_CALL = 3'b010,
    REGION_OPTION = 3'b011,
    REGION_PROTECT = 3'b100,
    REGION_FLASH = 3'b101,
    REGION_RAM = 3'b110,
    REGION_SFR = 3'b111
  } region_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'b00,
    ALU_SUB = 2'b01,
    ALU_ROL = 2'b10,
    ALU_ROR = 2'b11
  } alu_op_t;

  typedef struct packed {
    logic pc_adv;
    logic [2:0] pc_len;
    logic pc_load;
    logic [15:0] pc_value;
    logic ack;
    logic [1:0] ack_src;
    logic tcall;
    logic [4:0] tcall_idx;
    logic ie_clr;
    logic ie_set;
    logic push;
    logic push_psw;
    logic [7:0] push_data;
    logic pop;
    logic pop_psw;
    logic [7:0] pop_data;
    logic alu_we;
    alu_op_t alu_op;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic cy_we;
    logic cy_val;
    logic reg_we;
    logic reg_pair;
    logic [2:0] reg_sel;
    logic [15:0] reg_wdata;
  } core_cmd_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } stack_port_t;

endpackage

// ---- cpu_core_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - Sixteen-bit addresses span 64 KB space
// - Vector table 0000H-0013H, low byte even
// - Fixed vector addresses per interrupt source
// - Table call reads entry from 0040H-007FH
// - Option byte 0080H, protect byte 0081H
// - Flash size per variant from zero
// - 128-byte RAM is the only stack
// - FF00H-FFFFH decodes to peripheral registers
// - FE80H-FFFFH reachable by short addressing
// - Counter advances by length or loads branch
// - Reset loads counter from 0000H/0001H
// - Status word pushed and popped on stack
// - Status word resets to 02H
// - Interrupt flag low refuses all requests
// - Interrupt flag cleared by block, acknowledge
// - Zero flag follows zero add/subtract result
// - Half carry from bit 3 carry/borrow
// - Carry: overflow, rotate out, bit accumulator
// - Stack predecrement on write, postincrement on read
// - Ten writable bits, addresses fold into RAM
// - Eight byte registers, four pairs
module cpu_core_regs #(
  parameter int unsigned FLASH_BYTES = cpu_regs_pkg::FLASH_BYTES_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Core sequencer
  input wire cpu_regs_pkg::core_cmd_t cmd_in,
  input wire logic [3:0] irq_req_in,
  input wire logic [3:0] irq_mask_in,
  output logic busy_out,
  output logic irq_accept_out,
  // Program memory read port
  input wire logic [7:0] mem_rdata_in,
  output logic mem_rd_out,
  output logic [15:0] mem_addr_out,
  // Stack RAM port
  output cpu_regs_pkg::stack_port_t stack_out,
  // Address decoder
  input wire logic [15:0] decode_addr_in,
  output cpu_regs_pkg::region_t region_out,
  output logic short_ok_out,
  // Register views
  output logic [15:0] instr_pointer_out,
  output logic [7:0] proc_status_word_out,
  output logic [15:0] stack_ptr_out,
  output logic [15:0] reg_rdata_out,
  output logic [7:0] alu_result_out
);

  typedef struct packed {
    cpu_regs_pkg::fetch_t fsm;
    logic [15:0] fetch_addr;
    logic [7:0] fetch_lo;
    logic [15:0] pc;
    logic [7:0] processor_status_word;
    logic [9:0] sp;
    logic [7:0][7:0] gpr;
    logic [15:0] reg_rd;
    logic [7:0] alu_res;
    cpu_regs_pkg::region_t region;
    logic short_ok;
    cpu_regs_pkg::stack_port_t stk;
    logic dp_wr;
    logic [7:0] dp_ofs;
    logic [31:0] hrdata;
  } state_t;

  state_t q;
  state_t n;
  logic [9:0] sp_dec;
  logic [8:0] alu_wide;
  logic [4:0] nib_wide;

  function automatic logic [15:0] vec_addr(input logic [1:0] src);
    case (src)
      2'b00: vec_addr = cpu_regs_pkg::VEC_LOW_VOLT;
      2'b01: vec_addr = cpu_regs_pkg::VEC_EXT0;
      2'b10: vec_addr = cpu_regs_pkg::VEC_EXT1;
      default: vec_addr = cpu_regs_pkg::VEC_TIMER8;
    endcase
  endfunction

  // Any stack pointer value lands inside the RAM window
  function automatic logic [15:0] stack_addr(input logic [9:0] s);
    stack_addr = {cpu_regs_pkg::RAM_BASE[15:7], s[6:0]};
  endfunction

  function automatic cpu_regs_pkg::region_t region_of(input logic [15:0] a);
    if (a >= cpu_regs_pkg::SFR_BASE) begin
      region_of = cpu_regs_pkg::REGION_SFR;
    end else if (a >= cpu_regs_pkg::RAM_BASE && a <= cpu_regs_pkg::RAM_END) begin
      region_of = cpu_regs_pkg::REGION_RAM;
    end else if (a <= cpu_regs_pkg::VEC_TABLE_END) begin
      region_of = cpu_regs_pkg::REGION_VECTOR;
    end else if (a >= cpu_regs_pkg::SHORT_TABLE_CALL_BASE && a <= cpu_regs_pkg::SHORT_TABLE_CALL_END) begin
      region_of = cpu_regs_pkg::REGION_SHORT_TABLE_CALL;
    end else if (a == cpu_regs_pkg::OPTION_ADDR) begin
      region_of = cpu_regs_pkg::REGION_OPTION;
    end else if (a == cpu_regs_pkg::PROTECT_ADDR) begin
      region_of = cpu_regs_pkg::REGION_PROTECT;
    end else if (32'(a) < FLASH_BYTES) begin
      region_of = cpu_regs_pkg::REGION_FLASH;
    end else begin
      region_of = cpu_regs_pkg::REGION_NONE;
    end
  endfunction

  always_comb begin
    n = q;
    sp_dec = q.sp - cpu_regs_pkg::SP_ONE;
    alu_wide = 9'h000;
    nib_wide = 5'h00;
    n.stk.we = 1'b0;
    n.stk.re = 1'b0;
    unique case (q.fsm)
      cpu_regs_pkg::F_LO: begin
        n.fsm = cpu_regs_pkg::F_HI;
      end
      cpu_regs_pkg::F_HI: begin
        n.fetch_lo = mem_rdata_in;
        n.fsm = cpu_regs_pkg::F_DONE;
      end
      cpu_regs_pkg::F_DONE: begin
        n.pc = {mem_rdata_in, q.fetch_lo};
        n.fsm = cpu_regs_pkg::F_RUN;
      end
      cpu_regs_pkg::F_RUN: begin
        if (cmd_in.ie_clr) begin
          n.processor_status_word[cpu_regs_pkg::IE_BIT] = 1'b0;
        end else if (cmd_in.ie_set) begin
          n.processor_status_word[cpu_regs_pkg::IE_BIT] = 1'b1;
        end
        if (cmd_in.ack) begin
          n.processor_status_word[cpu_regs_pkg::IE_BIT] = 1'b0;
          n.fetch_addr = vec_addr(cmd_in.ack_src);
          n.fsm = cpu_regs_pkg::F_LO;
        end else if (cmd_in.tcall) begin
          n.fetch_addr = cpu_regs_pkg::SHORT_TABLE_CALL_BASE | {10'h000, cmd_in.tcall_idx, 1'b0};
          n.fsm = cpu_regs_pkg::F_LO;
        end else if (cmd_in.pc_load) begin
          n.pc = cmd_in.pc_value;
        end else if (cmd_in.pc_adv) begin
          n.pc = q.pc + {13'h0000, cmd_in.pc_len};
        end
        if (cmd_in.push || cmd_in.push_psw) begin
          n.sp = sp_dec;
          n.stk.we = 1'b1;
          n.stk.addr = stack_addr(sp_dec);
          n.stk.wdata = cmd_in.push_psw ? q.processor_status_word : cmd_in.push_data;
        end else if (cmd_in.pop || cmd_in.pop_psw) begin
          n.sp = q.sp + cpu_regs_pkg::SP_ONE;
          n.stk.re = 1'b1;
          n.stk.addr = stack_addr(q.sp);
          if (cmd_in.pop_psw) begin
            n.processor_status_word = cmd_in.pop_data;
          end
        end
        if (cmd_in.alu_we) begin
          unique case (cmd_in.alu_op)
            cpu_regs_pkg::ALU_ADD: begin
              alu_wide = {1'b0, cmd_in.alu_a} + {1'b0, cmd_in.alu_b};
              nib_wide = {1'b0, cmd_in.alu_a[3:0]} + {1'b0, cmd_in.alu_b[3:0]};
            end
            cpu_regs_pkg::ALU_SUB: begin
              alu_wide = {1'b0, cmd_in.alu_a} - {1'b0, cmd_in.alu_b};
              nib_wide = {1'b0, cmd_in.alu_a[3:0]} - {1'b0, cmd_in.alu_b[3:0]};
            end
            cpu_regs_pkg::ALU_ROL: begin
              alu_wide = {cmd_in.alu_a[7], cmd_in.alu_a[6:0], cmd_in.alu_a[7]};
            end
            cpu_regs_pkg::ALU_ROR: begin
              alu_wide = {cmd_in.alu_a[0], cmd_in.alu_a[0], cmd_in.alu_a[7:1]};
            end
          endcase
          n.alu_res = alu_wide[7:0];
          n.processor_status_word[cpu_regs_pkg::CY_BIT] = alu_wide[8];
          // Rotates leave zero and half carry alone
          if (!cmd_in.alu_op[1]) begin
            n.processor_status_word[cpu_regs_pkg::Z_BIT] = (alu_wide[7:0] == 8'h00);
            n.processor_status_word[cpu_regs_pkg::AC_BIT] = nib_wide[4];
          end
        end
        if (cmd_in.cy_we) begin
          n.processor_status_word[cpu_regs_pkg::CY_BIT] = cmd_in.cy_val;
        end
        if (cmd_in.reg_we) begin
          if (cmd_in.reg_pair) begin
            n.gpr[{cmd_in.reg_sel[1:0], 1'b0}] = cmd_in.reg_wdata[7:0];
            n.gpr[{cmd_in.reg_sel[1:0], 1'b1}] = cmd_in.reg_wdata[15:8];
          end else begin
            n.gpr[cmd_in.reg_sel] = cmd_in.reg_wdata[7:0];
          end
        end
      end
    endcase
    // Register read and address decode run every cycle
    if (cmd_in.reg_pair) begin
      n.reg_rd = {q.gpr[{cmd_in.reg_sel[1:0], 1'b1}], q.gpr[{cmd_in.reg_sel[1:0], 1'b0}]};
    end else begin
      n.reg_rd = {8'h00, q.gpr[cmd_in.reg_sel]};
    end
    n.region = region_of(decode_addr_in);
    n.short_ok = (decode_addr_in >= cpu_regs_pkg::SHORT_BASE);
    // Bus writes land last so software wins over the core
    if (q.dp_wr) begin
      unique case (q.dp_ofs)
        cpu_regs_pkg::OFS_INSTR_POINTER: n.pc = hwdata_in[15:0];
        cpu_regs_pkg::OFS_STATUS_WORD: n.processor_status_word = hwdata_in[7:0];
        cpu_regs_pkg::OFS_STACK_PTR: n.sp = hwdata_in[9:0];
        default: n.dp_wr = 1'b0;
      endcase
    end
    n.processor_status_word[cpu_regs_pkg::ONE_BIT] = 1'b1;
    n.dp_wr = 1'b0;
    if (hsel_in && hready_in && htrans_in[1]) begin
      n.dp_wr = hwrite_in;
      n.dp_ofs = haddr_in[7:0];
      // Read sees any write finishing this cycle
      unique case (haddr_in[7:0])
        cpu_regs_pkg::OFS_INSTR_POINTER: n.hrdata = {16'h0000, n.pc};
        cpu_regs_pkg::OFS_STATUS_WORD: n.hrdata = {24'h00_0000, n.processor_status_word};
        cpu_regs_pkg::OFS_STACK_PTR: n.hrdata = {16'h0000, cpu_regs_pkg::SP_HIGH, n.sp};
        cpu_regs_pkg::OFS_CORE_STATE: n.hrdata = {28'h000_0000, irq_accept_out, 1'b0, n.fsm};
        default: n.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.fsm <= cpu_regs_pkg::F_LO;
      q.fetch_addr <= cpu_regs_pkg::VEC_RESET;
      q.processor_status_word <= cpu_regs_pkg::PSW_RESET;
      q.sp <= cpu_regs_pkg::SP_RESET;
    end else begin
      q <= n;
    end
  end

  // Acceptance is a handshake, so it is left combinational
  assign irq_accept_out = q.processor_status_word[cpu_regs_pkg::IE_BIT] && |(irq_req_in & ~irq_mask_in);
  assign busy_out = (q.fsm != cpu_regs_pkg::F_RUN);
  assign mem_rd_out = (q.fsm == cpu_regs_pkg::F_LO) || (q.fsm == cpu_regs_pkg::F_HI);
  assign mem_addr_out = (q.fsm == cpu_regs_pkg::F_HI) ? (q.fetch_addr | 16'h0001) : q.fetch_addr;
  assign hrdata_out = q.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign stack_out = q.stk;
  assign region_out = q.region;
  assign short_ok_out = q.short_ok;
  assign instr_pointer_out = q.pc;
  assign proc_status_word_out = q.processor_status_word;
  assign stack_ptr_out = {cpu_regs_pkg::SP_HIGH, q.sp};
  assign reg_rdata_out = q.reg_rd;
  assign alu_result_out = q.alu_res;

  psw_one_bit_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    proc_status_word_out[cpu_regs_pkg::ONE_BIT])
    else $error("status word bit 1 not one");

  vector_pair_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    rstn_in && (q.fsm == cpu_regs_pkg::F_LO) |=> mem_rd_out
      && mem_addr_out == ($past(mem_addr_out) | 16'h0001))
    else $error("vector high byte not read from odd address");

  vector_load_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (q.fsm == cpu_regs_pkg::F_DONE)
      |=> instr_pointer_out == {$past(mem_rdata_in), $past(q.fetch_lo)}
      && !busy_out)
    else $error("counter not loaded from vector");

  irq_ack_clear_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.ack && !busy_out && !q.dp_wr)
      |=> !proc_status_word_out[cpu_regs_pkg::IE_BIT] ##1 busy_out)
    else $error("acknowledge did not clear interrupt flag");

  irq_refuse_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !proc_status_word_out[cpu_regs_pkg::IE_BIT] |-> !irq_accept_out)
    else $error("interrupt accepted while disabled");

  push_predec_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.push && !busy_out && !q.dp_wr) |=> stack_out.we
      && stack_ptr_out[9:0] == $past(stack_ptr_out[9:0]) - 10'h001
      && stack_out.addr == {cpu_regs_pkg::RAM_BASE[15:7], stack_ptr_out[6:0]})
    else $error("stack write without predecrement");

  stack_in_ram_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (stack_out.we || stack_out.re) |-> region_of(stack_out.addr) == cpu_regs_pkg::REGION_RAM)
    else $error("stack address outside RAM");

  zero_flag_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.alu_we && !cmd_in.alu_op[1] && !busy_out && !q.dp_wr)
      |=> proc_status_word_out[cpu_regs_pkg::Z_BIT] == (alu_result_out == 8'h00))
    else $error("zero flag wrong");

  pc_advance_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.pc_adv && !cmd_in.pc_load && !cmd_in.ack && !cmd_in.tcall && !busy_out && !q.dp_wr)
      |=> instr_pointer_out == $past(instr_pointer_out) + {13'h0000, $past(cmd_in.pc_len)})
    else $error("counter did not advance by length");

  sfr_decode_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    rstn_in && decode_addr_in >= cpu_regs_pkg::SFR_BASE |=> region_out == cpu_regs_pkg::REGION_SFR
      && short_ok_out)
    else $error("peripheral window not decoded");

  ram_decode_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (rstn_in && decode_addr_in >= cpu_regs_pkg::RAM_BASE
      && decode_addr_in <= cpu_regs_pkg::RAM_END)
      |=> region_out == cpu_regs_pkg::REGION_RAM && short_ok_out)
    else $error("data RAM window not decoded");

  half_carry_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.alu_we && cmd_in.alu_op == cpu_regs_pkg::ALU_ADD && !busy_out && !q.dp_wr)
      |=> proc_status_word_out[cpu_regs_pkg::AC_BIT]
      == ({1'b0, $past(cmd_in.alu_a[3:0])} + {1'b0, $past(cmd_in.alu_b[3:0])} > 5'h0f))
    else $error("half carry wrong on add");

  add_carry_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.alu_we && cmd_in.alu_op == cpu_regs_pkg::ALU_ADD && !cmd_in.cy_we && !busy_out
      && !q.dp_wr) |=> proc_status_word_out[cpu_regs_pkg::CY_BIT]
      == ({1'b0, $past(cmd_in.alu_a)} + {1'b0, $past(cmd_in.alu_b)} > 9'h0ff))
    else $error("carry wrong on add");

  rotate_carry_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.alu_we && cmd_in.alu_op[1] && !cmd_in.cy_we && !busy_out && !q.dp_wr)
      |=> proc_status_word_out[cpu_regs_pkg::CY_BIT] == ($past(cmd_in.alu_op[0])
      ? $past(cmd_in.alu_a[0]) : $past(cmd_in.alu_a[7])))
    else $error("rotate did not shift out into carry");

  ie_set_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.ie_set && !cmd_in.ie_clr && !cmd_in.ack && !cmd_in.pop_psw && !busy_out
      && !q.dp_wr) |=> proc_status_word_out[cpu_regs_pkg::IE_BIT])
    else $error("enable did not set interrupt flag");

  ie_block_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.ie_clr && !cmd_in.pop_psw && !busy_out && !q.dp_wr)
      |=> !proc_status_word_out[cpu_regs_pkg::IE_BIT])
    else $error("disable did not clear interrupt flag");

  pop_postinc_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.pop && !cmd_in.push && !cmd_in.push_psw && !busy_out && !q.dp_wr)
      |=> stack_out.re && stack_out.addr[6:0] == $past(stack_ptr_out[6:0])
      && stack_ptr_out[9:0] == $past(stack_ptr_out[9:0]) + 10'h001)
    else $error("stack read without postincrement");

  psw_push_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.push_psw && !busy_out)
      |=> stack_out.we && stack_out.wdata == $past(proc_status_word_out))
    else $error("status word not pushed");

  byte_read_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !cmd_in.reg_pair |=> reg_rdata_out[15:8] == 8'h00)
    else $error("single register read not one byte");

  vector_base_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.ack && !busy_out) |=> mem_rd_out
      && mem_addr_out == cpu_regs_pkg::VEC_LOW_VOLT + {13'h0000, $past(cmd_in.ack_src), 1'b0})
    else $error("vector fetch at wrong address");

  tcall_entry_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (cmd_in.tcall && !cmd_in.ack && !busy_out) |=> mem_rd_out
      && mem_addr_out == cpu_regs_pkg::SHORT_TABLE_CALL_BASE + {10'h000, $past(cmd_in.tcall_idx), 1'b0})
    else $error("table entry fetched from wrong address");

endmodule

// ---- prog_mem_model.sv ----
`timescale 1ns/1ps
module prog_mem_model #(
  parameter int unsigned FLASH_BYTES = 1024
) (
  // Clock
  input wire logic core_clk_in,
  // Program memory read port
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_rdata_out,
  // Stack RAM port
  input wire cpu_regs_pkg::stack_port_t stack_in
);
  logic [7:0] ram [128];

  initial mem_rdata_out = 8'h00;

  // Flash from zero, byte = low address ^ 5A, so vectors are low byte even
  always @(posedge core_clk_in) begin
    if (mem_rd_in) begin
      mem_rdata_out <= (mem_addr_in < FLASH_BYTES) ? (mem_addr_in[7:0] ^ 8'h5a) : 8'hff;
    end else begin
      // Released bus toggles so stale data never looks valid
      mem_rdata_out <= ~mem_rdata_out;
    end
    // Only the 128-byte RAM keeps stack bytes
    if (stack_in.we && stack_in.addr[15:7] == 9'h1fd) begin
      ram[stack_in.addr[6:0]] <= stack_in.wdata;
    end
  end
endmodule

// ---- cpu_core_regs_tb.sv ----
`timescale 1ns/1ps
module cpu_core_regs_tb;
  localparam int unsigned FB = 1024;
  localparam cpu_regs_pkg::alu_op_t ADD = cpu_regs_pkg::ALU_ADD;
  localparam cpu_regs_pkg::alu_op_t SUB = cpu_regs_pkg::ALU_SUB;
  localparam cpu_regs_pkg::alu_op_t ROL = cpu_regs_pkg::ALU_ROL;
  localparam cpu_regs_pkg::alu_op_t ROR = cpu_regs_pkg::ALU_ROR;
  typedef struct packed {
    logic [15:0] a;
    cpu_regs_pkg::region_t r;
    logic s;
  } dec_row_t;
  typedef struct packed {
    cpu_regs_pkg::alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] y;
    logic [2:0] f;
  } alu_row_t;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] req = 4'h0;
  logic [3:0] mask = 4'h0;
  logic [15:0] dec = 16'h0000;
  cpu_regs_pkg::core_cmd_t cmd = '0;
  logic hready, hresp, busy, acc, mem_rd, sok;
  logic [31:0] hrdata, rd;
  logic [7:0] mem_q, processor_status_word, alu_q;
  logic [15:0] mem_a, pc, sp, rq;
  cpu_regs_pkg::stack_port_t stk;
  cpu_regs_pkg::region_t reg_q;
  dec_row_t drow [12];
  alu_row_t arow [9];
  logic [15:0] vtab [4];
  int err_count = 0;
  int n_compared = 0;
  int i;

  always #2.5 clk = ~clk;

  cpu_core_regs #(.FLASH_BYTES(FB)) dut (.core_clk_in(clk), .rstn_in(rstn), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .cmd_in(cmd), .irq_req_in(req), .irq_mask_in(mask), .busy_out(busy),
    .irq_accept_out(acc), .mem_rdata_in(mem_q), .mem_rd_out(mem_rd), .mem_addr_out(mem_a),
    .stack_out(stk), .decode_addr_in(dec), .region_out(reg_q), .short_ok_out(sok),
    .instr_pointer_out(pc), .proc_status_word_out(processor_status_word), .stack_ptr_out(sp),
    .reg_rdata_out(rq), .alu_result_out(alu_q));

  prog_mem_model #(.FLASH_BYTES(FB)) mem (.core_clk_in(clk), .mem_rd_in(mem_rd),
    .mem_addr_in(mem_a), .mem_rdata_out(mem_q), .stack_in(stk));

  // Vector word as the flash model stores it
  function automatic logic [15:0] vec(input logic [15:0] a);
    return {(a[7:0] + 8'h01) ^ 8'h5a, a[7:0] ^ 8'h5a};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bounded wait: bus ready at the edge, or core idle after the edge settles
  task automatic wait_for(input bit idle);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      if (idle) #1;
      n++;
    end while ((idle ? busy : ~hready) !== 1'h0 && n < 40);
    if ((idle ? busy : ~hready) !== 1'h0) begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    wait_for(1'h0);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(1'h0);
    rd = hrdata;
  endtask

  task automatic run(input cpu_regs_pkg::core_cmd_t x);
    @(posedge clk);
    cmd <= x;
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask

  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    drow = '{'{16'h0013, cpu_regs_pkg::REGION_VECTOR, 1'h0},
      '{16'h0014, cpu_regs_pkg::REGION_FLASH, 1'h0}, '{16'h007f, cpu_regs_pkg::REGION_SHORT_TABLE_CALL, 1'h0},
      '{16'h0080, cpu_regs_pkg::REGION_OPTION, 1'h0},
      '{16'h0081, cpu_regs_pkg::REGION_PROTECT, 1'h0},
      '{16'h03ff, cpu_regs_pkg::REGION_FLASH, 1'h0}, '{16'h0400, cpu_regs_pkg::REGION_NONE, 1'h0},
      '{16'hfe7f, cpu_regs_pkg::REGION_NONE, 1'h0}, '{16'hfe80, cpu_regs_pkg::REGION_RAM, 1'h1},
      '{16'hfeff, cpu_regs_pkg::REGION_RAM, 1'h1}, '{16'hff00, cpu_regs_pkg::REGION_SFR, 1'h1},
      '{16'hffff, cpu_regs_pkg::REGION_SFR, 1'h1}};
    // Flags column is {zero, half carry, carry}; rotates leave zero and half carry alone
    arow = '{'{ADD, 8'h0f, 8'h01, 8'h10, 3'h2}, '{ADD, 8'hff, 8'h01, 8'h00, 3'h7},
      '{ADD, 8'h12, 8'h34, 8'h46, 3'h0}, '{SUB, 8'h10, 8'h01, 8'h0f, 3'h2},
      '{SUB, 8'h00, 8'h01, 8'hff, 3'h3}, '{SUB, 8'h55, 8'h55, 8'h00, 3'h4},
      '{ROL, 8'h80, 8'h00, 8'h01, 3'h5}, '{ROR, 8'h01, 8'h00, 8'h80, 3'h5},
      '{ROR, 8'h02, 8'h00, 8'h01, 3'h4}};
    vtab = '{16'h0006, 16'h0008, 16'h000a, 16'h000c};
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    #1;
    chk("psw_rst", processor_status_word, 32'h0000_0002);
    wait_for(1'h1);
    chk("pc_rst", pc, vec(16'h0000));
    $display("reset test done");
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      dec <= drow[i].a;
      @(posedge clk);
      #1;
      chk("region", reg_q, drow[i].r);
      chk("short", sok, drow[i].s);
    end
    for (i = 0; i < 9; i++) begin
      run('{alu_we: 1'h1, alu_op: arow[i].op, alu_a: arow[i].a, alu_b: arow[i].b, default: '0});
      chk("alu", alu_q, arow[i].y);
      chk("flags", {processor_status_word[6], processor_status_word[4], processor_status_word[0]}, arow[i].f);
    end
    // Direct carry write must beat the adder's carry out
    run('{alu_we: 1'h1, alu_op: ADD, alu_a: 8'hff, alu_b: 8'h01, cy_we: 1'h1, default: '0});
    chk("cy_direct", processor_status_word[0], 1'h0);
    $display("decode and flag tests done");
    @(posedge clk);
    req <= 4'hf;
    @(posedge clk);
    #1;
    chk("acc_off", acc, 1'h0);
    for (i = 0; i < 4; i++) begin
      run('{ie_set: 1'h1, alu_op: ADD, default: '0});
      chk("acc_on", acc, 1'h1);
      run('{ack: 1'h1, ack_src: i[1:0], alu_op: ADD, default: '0});
      wait_for(1'h1);
      chk("pc_vec", pc, vec(vtab[i]));
      chk("ie_ack", processor_status_word[7], 1'h0);
    end
    run('{ie_set: 1'h1, alu_op: ADD, default: '0});
    @(posedge clk);
    mask <= 4'hf;
    @(posedge clk);
    #1;
    chk("acc_mask", acc, 1'h0);
    run('{ie_set: 1'h1, ie_clr: 1'h1, alu_op: ADD, default: '0});
    chk("ie_clr", processor_status_word[7], 1'h0);
    $display("interrupt tests done");
    run('{pc_load: 1'h1, pc_value: 16'h1000, pc_adv: 1'h1, pc_len: 3'h3, alu_op: ADD,
      default: '0});
    chk("pc_load", pc, 16'h1000);
    run('{pc_adv: 1'h1, pc_len: 3'h3, alu_op: ADD, default: '0});
    chk("pc_adv", pc, 16'h1003);
    for (i = 0; i < 2; i++) begin
      run('{tcall: 1'h1, tcall_idx: (i == 0) ? 5'h00 : 5'h1f, alu_op: ADD, default: '0});
      wait_for(1'h1);
      chk("tcall", pc, vec((i == 0) ? 16'h0040 : 16'h007e));
    end
    $display("program counter tests done");
    // Stack pointer must be loaded before any stack use
    bus(1'h1, 8'h08, 32'hffff_ff00);
    bus(1'h0, 8'h08, 32'h0000_0000);
    chk("sp_rd", rd, 32'h0000_fb00);
    bus(1'h1, 8'h04, 32'h0000_00d1);
    bus(1'h0, 8'h04, 32'h0000_0000);
    chk("psw_rd", rd, 32'h0000_00d3);
    run('{push: 1'h1, push_data: 8'ha5, alu_op: ADD, default: '0});
    chk("push", {stk.we, stk.addr, stk.wdata}, {1'h1, 16'hfeff, 8'ha5});
    chk("sp_dec", sp, 16'hfaff);
    run('{push_psw: 1'h1, alu_op: ADD, default: '0});
    chk("push_psw", {stk.we, stk.addr, stk.wdata}, {1'h1, 16'hfefe, 8'hd3});
    chk("ram", mem.ram[127], 8'ha5);
    run('{pop_psw: 1'h1, pop_data: 8'h51, alu_op: ADD, default: '0});
    chk("pop", {stk.re, stk.addr}, {1'h1, 16'hfefe});
    chk("psw_pop", processor_status_word, 8'h53);
    run('{pop: 1'h1, alu_op: ADD, default: '0});
    chk("sp_inc", sp, 16'hfb00);
    bus(1'h1, 8'h08, 32'h0000_0000);
    run('{push: 1'h1, alu_op: ADD, default: '0});
    chk("wrap", {stk.addr, sp}, {16'hfeff, 16'hfbff});
    $display("stack tests done");
    run('{reg_we: 1'h1, reg_pair: 1'h1, reg_sel: 3'h1, reg_wdata: 16'h1234, alu_op: ADD,
      default: '0});
    run('{reg_we: 1'h1, reg_sel: 3'h3, reg_wdata: 16'h00ab, alu_op: ADD, default: '0});
    run('{reg_pair: 1'h1, reg_sel: 3'h1, alu_op: ADD, default: '0});
    chk("pair", rq, 16'hab34);
    run('{reg_sel: 3'h2, alu_op: ADD, default: '0});
    chk("byte", rq, 16'h0034);
    bus(1'h1, 8'h00, 32'h0000_4321);
    bus(1'h0, 8'h00, 32'h0000_0000);
    chk("pc_bus", rd, 32'h0000_4321);
    bus(1'h1, 8'h10, 32'h1234_5678);
    bus(1'h0, 8'h10, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    chk("hresp", hresp, 1'h0);
    bus(1'h1, 8'h0c, 32'hffff_ffff);
    bus(1'h0, 8'h0c, 32'h0000_0000);
    chk("state", rd, 32'h0000_0000);
    $display("register tests done");
    @(posedge clk);
    rstn <= 1'h0;
    @(posedge clk);
    #1;
    chk("psw_rst2", processor_status_word, 32'h0000_0002);
    @(posedge clk);
    rstn <= 1'h1;
    wait_for(1'h1);
    chk("pc_rst2", pc, vec(16'h0000));
    $display("second reset test done");
    finish_test();
  end
endmodule
